// file: card_uart_pkg.sv
// Constants for the card UART host I/O and modem pin block
package card_uart_pkg;
  // Modem status fields
  localparam int MSR_DCTS = 0;
  localparam int MSR_DDSR = 1;
  localparam int MSR_DDCD = 3;
  localparam int MSR_CTS = 4;
  localparam int MSR_DSR = 5;
  localparam int MSR_DCD = 7;
  // Modem control, FIFO control and enable fields
  localparam int MCR_TREADY = 0;
  localparam int MCR_LOOP = 4;
  localparam int FCR_AUTORTS = 4;
  localparam int FCR_EXT64 = 5;
  localparam int FCR_TRIG_LO = 6;
  localparam int IER_MSTAT = 3;
  localparam int CFG_READY = 0;
  localparam int CFG_COMPORT = 1;
  // Host I/O register indices
  localparam logic [2:0] IO_IER = 3'h1;
  localparam logic [2:0] IO_FCR = 3'h2;
  localparam logic [2:0] IO_MCR = 3'h4;
  localparam logic [2:0] IO_MSR = 3'h6;
  // Bus byte offsets; UART registers sit at index times four
  localparam logic [7:0] OFF_IER = 8'h04;
  localparam logic [7:0] OFF_FCR = 8'h08;
  localparam logic [7:0] OFF_MCR = 8'h10;
  localparam logic [7:0] OFF_MSR = 8'h18;
  localparam logic [7:0] OFF_CFG = 8'h20;
  localparam logic [7:0] OFF_STAT = 8'h24;
  // Reset values
  localparam logic [7:0] MCR_RST = 8'h00;
  localparam logic [7:0] FCR_RST = 8'h00;
  localparam logic [7:0] IER_RST = 8'h00;
  localparam logic [7:0] CFG_RST = 8'h00;
  localparam logic [6:0] COM_BASE_DEF = 7'h7F;
  // FIFO depths and receiver trigger levels
  localparam logic [6:0] DEPTH_STD = 7'h10;
  localparam logic [6:0] DEPTH_EXT = 7'h40;
  localparam logic [6:0] TRIG_STD1 = 7'h04;
  localparam logic [6:0] TRIG_STD2 = 7'h08;
  localparam logic [6:0] TRIG_STD3 = 7'h0E;
  localparam logic [6:0] TRIG_EXT1 = 7'h10;
  localparam logic [6:0] TRIG_EXT2 = 7'h20;
  localparam logic [6:0] TRIG_EXT3 = 7'h38;
  localparam logic [6:0] TRIG_ONE = 7'h01;
  // Pin synchroniser: modem, extend, strobes, address, data
  localparam int SYNC_W = 28;
  localparam logic [SYNC_W-1:0] SYNC_RST = 28'hFFC0000;
endpackage

// file: card_uart_host_io.sv
// Host I/O decode and modem control and status pins of the card UART
//
// The AHB-Lite slave port and the register offsets were decided locally.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Clear-to-send level shows in status bit 4; bit 0 flags its changes.
// - Carrier-detect level shows in status bit 7; bit 3 flags its changes.
// - Data-set-ready level shows in status bit 5; bit 1 flags its changes.
// - Reading modem status clears the change flags.
// - Enabled modem-status interrupt fires on any modem input change.
// - Terminal-ready output goes low when control bit 0 is one and loop bit 4 is zero.
// - Terminal-ready is inactive on reset, in loop mode, or bit 0 clear.
// - Extend pin high gives 16-byte FIFOs.
// - Extend pin low with FIFO control bit 5 gives 64 bytes, rescaled triggers.
// - Auto request-to-send only with extend low and FIFO control bit 4.
// - Ten-bit host address; UART at bits 0-2 or bits 0-9 as a port.
// - Eight-bit host data bus, driven only during host reads.
// - Input acknowledge goes low while answering a host I/O read.
// - Host interrupt request low on service need; busy low before ready.
// - Host attribute write raises a subsystem interrupt pulse.
module card_uart_host_io
  import card_uart_pkg::*;
#(
  parameter logic [6:0] COM_BASE = COM_BASE_DEF
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Host card pins
  input wire logic [9:0] host_address_bus,
  input wire logic [7:0] host_data_bus_in,
  output logic [7:0] host_data_bus_out,
  output logic host_data_bus_oe,
  input wire logic card_en1_n,
  input wire logic card_en2_n,
  input wire logic attr_sel_n,
  input wire logic io_rd_n,
  input wire logic io_wr_n,
  input wire logic mem_wr_n,
  output logic in_ack_n,
  output logic host_irq_n,
  // Subsystem side
  output logic subsys_irq,
  output logic auto_rts_en,
  output logic [6:0] fifo_depth,
  output logic [6:0] rx_trigger,
  // Modem pins
  input wire logic clear_to_send_n,
  input wire logic carrier_detect_n,
  input wire logic set_ready_n,
  input wire logic fifo_extend,
  output logic term_ready_n
);

  logic [SYNC_W-1:0] meta_reg;
  logic [SYNC_W-1:0] sync_reg;
  logic cts_s, dcd_s, dsr_s, ext_s, iord_s, iowr_s, we_s;
  logic reg_s, ce1_s, ce2_s;
  logic [9:0] ha_s;
  logic [7:0] hd_s;
  logic [7:0] mcr_reg, fcr_reg, ier_reg, cfg_reg;
  logic [2:0] lvl_q_reg, delta_reg, lvl, change;
  logic [7:0] msr_val;
  logic card_sel, addr_hit, io_rd, io_wr, attr_wr;
  logic io_rd_q_reg, io_wr_q_reg, attr_wr_q_reg;
  logic rd_start, wr_start, msr_clr;
  logic [7:0] host_rdata_reg;
  logic drive_reg;
  logic ireq_n_reg, subsys_irq_reg;
  logic ahb_go, ahb_rd, ahb_wr_reg;
  logic [7:0] ahb_addr_reg;
  logic [31:0] hrdata_reg;
  logic ext64;

  // Both stages take the whole vector; logic reads only the second
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta_reg <= SYNC_RST;
      sync_reg <= SYNC_RST;
    end else begin
      meta_reg <= {clear_to_send_n, carrier_detect_n, set_ready_n,
                   fifo_extend, io_rd_n, io_wr_n, mem_wr_n, attr_sel_n,
                   card_en1_n, card_en2_n, host_address_bus,
                   host_data_bus_in};
      sync_reg <= meta_reg;
    end
  end

  assign {cts_s, dcd_s, dsr_s, ext_s, iord_s, iowr_s, we_s, reg_s,
          ce1_s, ce2_s, ha_s, hd_s} = sync_reg;

  function automatic logic [7:0] uart_read(input logic [2:0] idx,
      input logic [7:0] modem_status_reg, input logic [7:0] modem_control_reg,
      input logic [7:0] fifo_control_reg, input logic [7:0] ier);
    case (idx)
      IO_IER: uart_read = ier;
      IO_FCR: uart_read = fifo_control_reg;
      IO_MCR: uart_read = modem_control_reg;
      IO_MSR: uart_read = modem_status_reg;
      default: uart_read = 8'h00;
    endcase
  endfunction

  function automatic logic [6:0] trig_level(input logic ext,
      input logic [1:0] sel);
    case (sel)
      2'h0: trig_level = TRIG_ONE;
      2'h1: trig_level = ext ? TRIG_EXT1 : TRIG_STD1;
      2'h2: trig_level = ext ? TRIG_EXT2 : TRIG_STD2;
      default: trig_level = ext ? TRIG_EXT3 : TRIG_STD3;
    endcase
  endfunction

  // Modem levels, active low at the pins
  assign lvl = {~dcd_s, ~dsr_s, ~cts_s};
  assign change = lvl ^ lvl_q_reg;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lvl_q_reg <= 3'h0;
    end else begin
      lvl_q_reg <= lvl;
    end
  end

  // A change in the clearing cycle is kept: set beats clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      delta_reg <= 3'h0;
    end else begin
      delta_reg <= (delta_reg & ~{3{msr_clr}}) | change;
    end
  end

  always_comb begin
    msr_val = 8'h00;
    msr_val[MSR_CTS] = lvl[0];
    msr_val[MSR_DCTS] = delta_reg[0];
    msr_val[MSR_DSR] = lvl[1];
    msr_val[MSR_DDSR] = delta_reg[1];
    msr_val[MSR_DCD] = lvl[2];
    msr_val[MSR_DDCD] = delta_reg[2];
  end

  // Host cycle qualification
  assign card_sel = ~reg_s & (~ce1_s | ~ce2_s);
  assign addr_hit = cfg_reg[CFG_COMPORT] ? (ha_s[9:3] == COM_BASE)
                                         : 1'b1;
  assign io_rd = card_sel & addr_hit & ~iord_s;
  assign io_wr = card_sel & addr_hit & ~iowr_s;
  assign attr_wr = card_sel & ~we_s;
  assign rd_start = io_rd & ~io_rd_q_reg;
  assign wr_start = io_wr & ~io_wr_q_reg;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      io_rd_q_reg <= 1'b0;
      io_wr_q_reg <= 1'b0;
      attr_wr_q_reg <= 1'b0;
    end else begin
      io_rd_q_reg <= io_rd;
      io_wr_q_reg <= io_wr;
      attr_wr_q_reg <= attr_wr;
    end
  end

  // Read data is captured once per strobe so flags clear exactly once
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      host_rdata_reg <= 8'h00;
      drive_reg <= 1'b0;
    end else begin
      drive_reg <= io_rd;
      if (rd_start) begin
        host_rdata_reg <= uart_read(ha_s[2:0], msr_val, mcr_reg,
                                    fcr_reg, ier_reg);
      end
    end
  end

  assign host_data_bus_out = host_rdata_reg;
  assign host_data_bus_oe = drive_reg;
  assign in_ack_n = ~drive_reg;

  // AHB-Lite slave, zero wait states
  assign ahb_go = hsel & htrans[1] & hready;
  assign ahb_rd = ahb_go & ~hwrite;
  assign msr_clr = (rd_start & (ha_s[2:0] == IO_MSR))
                 | (ahb_rd & (haddr[7:0] == OFF_MSR));

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ahb_wr_reg <= 1'b0;
      ahb_addr_reg <= 8'h00;
      hrdata_reg <= 32'h0;
    end else begin
      ahb_wr_reg <= ahb_go & hwrite;
      ahb_addr_reg <= haddr[7:0];
      hrdata_reg <= 32'h0;
      if (ahb_rd && haddr[31:8] == 24'h0) begin
        case (haddr[7:0])
          OFF_IER, OFF_FCR, OFF_MCR, OFF_MSR:
            hrdata_reg <= {24'h0, uart_read(haddr[4:2], msr_val,
                           mcr_reg, fcr_reg, ier_reg)};
          OFF_CFG: hrdata_reg <= {24'h0, cfg_reg};
          OFF_STAT: hrdata_reg <= {16'h0, 1'b0, rx_trigger,
                                   auto_rts_en, fifo_depth};
          default: hrdata_reg <= 32'h0;
        endcase
      end
    end
  end

  assign hrdata = hrdata_reg;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // Control registers; a bus write wins over a host write
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mcr_reg <= MCR_RST;
      fcr_reg <= FCR_RST;
      ier_reg <= IER_RST;
      cfg_reg <= CFG_RST;
    end else if (ahb_wr_reg) begin
      case (ahb_addr_reg)
        OFF_IER: ier_reg <= hwdata[7:0];
        OFF_FCR: fcr_reg <= hwdata[7:0];
        OFF_MCR: mcr_reg <= hwdata[7:0];
        OFF_CFG: cfg_reg <= hwdata[7:0];
        default: cfg_reg <= cfg_reg;
      endcase
    end else if (wr_start) begin
      case (ha_s[2:0])
        IO_IER: ier_reg <= hd_s;
        IO_FCR: fcr_reg <= hd_s;
        IO_MCR: mcr_reg <= hd_s;
        default: ier_reg <= ier_reg;
      endcase
    end
  end

  // Loop mode keeps the modem line quiet
  assign term_ready_n = ~(mcr_reg[MCR_TREADY] &
                          ~mcr_reg[MCR_LOOP]);

  // FIFO mode
  assign ext64 = ~ext_s & fcr_reg[FCR_EXT64];
  assign fifo_depth = ext64 ? DEPTH_EXT : DEPTH_STD;
  assign rx_trigger = trig_level(ext64,
                                 fcr_reg[FCR_TRIG_LO+1:FCR_TRIG_LO]);
  assign auto_rts_en = ~ext_s & fcr_reg[FCR_AUTORTS];

  // Busy (low) until the subsystem marks the card ready
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ireq_n_reg <= 1'b0;
      subsys_irq_reg <= 1'b0;
    end else begin
      ireq_n_reg <= cfg_reg[CFG_READY] ?
                    ~(ier_reg[IER_MSTAT] & |delta_reg) : 1'b0;
      subsys_irq_reg <= attr_wr & ~attr_wr_q_reg;
    end
  end

  assign host_irq_n = ireq_n_reg;
  assign subsys_irq = subsys_irq_reg;

  chk_cts_delta_set: assert property (@(posedge hclk) disable iff (!hresetn)
    change[0] |=> delta_reg[0] && msr_val[MSR_DCTS])
    else $error("cts change not flagged");
  chk_dcd_level: assert property (@(posedge hclk) disable iff (!hresetn)
    $fell(dcd_s) |-> msr_val[MSR_DCD] ##1 msr_val[MSR_DDCD])
    else $error("dcd level or flag wrong");
  chk_dsr_delta_set: assert property (@(posedge hclk) disable iff (!hresetn)
    $changed(dsr_s) |=> msr_val[MSR_DDSR])
    else $error("dsr change not flagged");
  chk_msr_read_clear: assert property (@(posedge hclk)
    disable iff (!hresetn)
    msr_clr && change == 3'h0 |=> delta_reg == 3'h0)
    else $error("delta flags not cleared");
  chk_ms_irq: assert property (@(posedge hclk) disable iff (!hresetn)
    cfg_reg[CFG_READY] && ier_reg[IER_MSTAT] && change[1]
    |-> ##2 !host_irq_n)
    else $error("modem interrupt missing");
  chk_busy_low: assert property (@(posedge hclk) disable iff (!hresetn)
    !$past(cfg_reg[CFG_READY]) |-> !host_irq_n)
    else $error("busy not shown");
  chk_term_ready: assert property (@(posedge hclk) disable iff (!hresetn)
    !term_ready_n |-> mcr_reg[MCR_TREADY] && !mcr_reg[MCR_LOOP])
    else $error("terminal ready wrong");
  chk_fifo_mode: assert property (@(posedge hclk) disable iff (!hresetn)
    ext_s |-> fifo_depth == DEPTH_STD && !auto_rts_en
    && rx_trigger != TRIG_EXT3)
    else $error("extend pin ignored");
  chk_ext_depth: assert property (@(posedge hclk) disable iff (!hresetn)
    !ext_s && fcr_reg[FCR_EXT64] |-> fifo_depth == DEPTH_EXT)
    else $error("extended depth missing");
  chk_read_drive: assert property (@(posedge hclk) disable iff (!hresetn)
    rd_start |=> host_data_bus_oe && !in_ack_n)
    else $error("read not answered");
  chk_idle_bus: assert property (@(posedge hclk) disable iff (!hresetn)
    !card_sel |=> !host_data_bus_oe && in_ack_n)
    else $error("bus driven while deselected");
  chk_attr_irq: assert property (@(posedge hclk) disable iff (!hresetn)
    attr_wr && !attr_wr_q_reg |=> subsys_irq ##1 !subsys_irq)
    else $error("attribute write interrupt wrong");
  chk_com_decode: assert property (@(posedge hclk) disable iff (!hresetn)
    cfg_reg[CFG_COMPORT] && ha_s[9:3] != COM_BASE |-> !io_rd)
    else $error("port decode wrong");

endmodule
`default_nettype wire

// file: card_host_model.sv
// Host controller and modem pin model facing the card UART
`timescale 1ns/1ps
`default_nettype none
module card_host_model (
  // Clock
  input wire logic hclk,
  // Host bus pins
  output logic [9:0] host_address_bus,
  output logic [7:0] host_data_bus_in,
  input wire logic [7:0] host_data_bus_out,
  input wire logic host_data_bus_oe,
  output logic card_en1_n,
  output logic card_en2_n,
  output logic attr_sel_n,
  output logic io_rd_n,
  output logic io_wr_n,
  output logic mem_wr_n,
  input wire logic in_ack_n,
  // Modem pins
  output logic clear_to_send_n,
  output logic carrier_detect_n,
  output logic set_ready_n
);
  logic [7:0] dq_reg;
  logic dq_en;
  logic [7:0] idle_reg;
  // Released bus wanders so a stale byte never passes as read data
  always @(posedge hclk) idle_reg <= idle_reg + 8'h3B;
  assign host_data_bus_in = host_data_bus_oe ? host_data_bus_out :
    (dq_en ? dq_reg : idle_reg);
  initial begin
    {card_en1_n, card_en2_n, attr_sel_n, io_rd_n, io_wr_n} = 5'h1F;
    {mem_wr_n, clear_to_send_n, carrier_detect_n, set_ready_n} = 4'hF;
    host_address_bus = 10'h000;
    {dq_reg, dq_en, idle_reg} = 17'h000A5;
  end
  task automatic qualify(input logic [9:0] a, input logic on);
    host_address_bus <= a;
    card_en1_n <= !(on && !a[0]);
    card_en2_n <= !(on && a[0]);
    attr_sel_n <= !on;
  endtask
  task automatic idle(input int n);
    {card_en1_n, card_en2_n, attr_sel_n, io_rd_n, io_wr_n} <= 5'h1F;
    mem_wr_n <= 1'b1;
    dq_en <= 1'b0;
    repeat (n) @(posedge hclk);
  endtask
  // Strobe held until acknowledge or eight cycles pass
  task automatic read(input logic [9:0] a, input logic on,
      output logic [7:0] d, output logic ack);
    ack = 1'b0;
    d = 8'h00;
    qualify(a, on);
    io_rd_n <= 1'b0;
    for (int n = 0; n < 8 && !ack; n++) begin
      @(posedge hclk);
      ack = (in_ack_n === 1'b0);
      d = host_data_bus_in;
    end
    idle(5);
  endtask
  // Data settles two cycles ahead of the strobe
  task automatic write(input logic [9:0] a, input logic [7:0] d,
      input logic on, input logic mem);
    qualify(a, on);
    dq_reg <= d;
    dq_en <= 1'b1;
    repeat (2) @(posedge hclk);
    if (mem) mem_wr_n <= 1'b0;
    else io_wr_n <= 1'b0;
    repeat (4) @(posedge hclk);
    idle(4);
  endtask
  task automatic modem(input logic [2:0] lv);
    {carrier_detect_n, set_ready_n, clear_to_send_n} <= ~lv;
  endtask
endmodule
`default_nettype wire

// file: card_uart_host_io_tb.sv
// Self-checking bench for the card UART host I/O and modem pins
`timescale 1ns/1ps
`default_nettype none
module card_uart_host_io_tb;
  import card_uart_pkg::*;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [9:0] host_address_bus;
  logic [7:0] host_data_bus_in, host_data_bus_out, f, d;
  logic host_data_bus_oe, card_en1_n, card_en2_n, attr_sel_n, io_rd_n;
  logic io_wr_n, mem_wr_n, in_ack_n, host_irq_n, subsys_irq, auto_rts_en;
  logic clear_to_send_n, carrier_detect_n, set_ready_n, fifo_extend;
  logic term_ready_n, ak;
  logic [6:0] fifo_depth, rx_trigger;
  logic [2:0] lv, nv;
  logic [7:0] mcr_v [4] = '{8'h01, 8'h11, 8'h00, 8'h01};
  int bad_count, cmp_count, pulses, p0, seed;
  assign hready = hreadyout;
  card_uart_host_io u_dut (.*);
  card_host_model u_host (.*);
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  always @(posedge hclk) if (subsys_irq === 1'b1) pulses++;
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD at %0t: saw %h wanted %h", $time, got, exp);
    end
  endtask
  task automatic summarize;
    $display("Counts: %0d compares, %0d bad", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic ahb(input logic w, input logic [7:0] a,
      input logic [31:0] wd, output logic [31:0] rd);
    {hsel, hwrite, htrans, haddr} <= {1'b1, w, 2'b10, 24'h0, a};
    do @(posedge hclk); while (hready !== 1'b1);
    {hsel, htrans, hwdata} <= {3'h0, wd};
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    logic [31:0] r;
    ahb(1'b1, a, {24'h0, v}, r);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    ahb(1'b0, a, 32'h0, r);
    check(r, e);
  endtask
  function automatic logic [14:0] stat(input logic x, input logic [7:0] v);
    logic big;
    logic [6:0] t;
    big = !x && v[FCR_EXT64];
    case (v[7:6])
      2'h0: t = TRIG_ONE;
      2'h1: t = big ? TRIG_EXT1 : TRIG_STD1;
      2'h2: t = big ? TRIG_EXT2 : TRIG_STD2;
      default: t = big ? TRIG_EXT3 : TRIG_STD3;
    endcase
    return {t, !x && v[FCR_AUTORTS], big ? DEPTH_EXT : DEPTH_STD};
  endfunction
  function automatic logic [7:0] modem_status_reg(input logic [2:0] l, input logic [2:0] c);
    return {l[2], 1'b0, l[1], l[0], c[2], 1'b0, c[1], c[0]};
  endfunction
  initial begin
    #200000;
    bad_count++;
    $display("BAD at %0t: watchdog expired", $time);
    summarize();
  end
  initial begin
    {hresetn, hsel, hwrite, htrans, haddr, hwdata} = 69'h0;
    {hsize, fifo_extend, lv, pulses, bad_count, cmp_count} = 0;
    hsize = 3'h2;
    fifo_extend = 1'b1;
    seed = $urandom(22);
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    check({term_ready_n, host_irq_n, in_ack_n}, 3'b101);
    $display("Test reset done");
    for (int i = 0; i < 4; i++) begin
      wr(OFF_MCR, mcr_v[i]);
      @(posedge hclk);
      check(term_ready_n, !(mcr_v[i] == 8'h01));
    end
    u_host.write(10'h3FC, 8'h00, 1'b1, 1'b0);
    check(term_ready_n, 1'b1);
    u_host.write(10'h004, 8'h01, 1'b0, 1'b0);
    check(term_ready_n, 1'b1);
    $display("Test terminal ready done");
    for (int i = 0; i < 12; i++) begin
      f = (i == 0) ? 8'hF0 : 8'($urandom);
      fifo_extend <= i[0];
      if (i[1]) u_host.write(10'h002, f, 1'b1, 1'b0);
      else wr(OFF_FCR, f);
      repeat (3) @(posedge hclk);
      check({rx_trigger, auto_rts_en, fifo_depth}, stat(i[0], f));
      rdchk(OFF_STAT, {17'h0, stat(i[0], f)});
    end
    $display("Test fifo mode done");
    wr(OFF_CFG, 8'h01);
    u_host.write(10'h001, 8'h08, 1'b1, 1'b0);
    rdchk(OFF_IER, 32'h08);
    check(host_irq_n, 1'b1);
    // A change undone before the read still leaves its flag
    u_host.modem(3'b001);
    repeat (3) @(posedge hclk);
    u_host.modem(3'b000);
    repeat (6) @(posedge hclk);
    check(host_irq_n, 1'b0);
    rdchk(OFF_MSR, 32'h01);
    for (int i = 0; i < 10; i++) begin
      nv = (i == 0) ? 3'b111 : 3'($urandom);
      u_host.modem(nv);
      repeat (6) @(posedge hclk);
      check(host_irq_n, nv == lv);
      if (i[0]) begin
        u_host.read(10'h3AE, 1'b1, d, ak);
        check({ak, host_data_bus_oe, d}, {2'b10, modem_status_reg(nv, nv ^ lv)});
      end else begin
        rdchk(OFF_MSR, modem_status_reg(nv, nv ^ lv));
      end
      lv = nv;
    end
    rdchk(OFF_MSR, modem_status_reg(lv, 3'b000));
    $display("Test modem status done");
    wr(OFF_CFG, 8'h03);
    u_host.read({COM_BASE_DEF, 3'h6}, 1'b1, d, ak);
    check(ak, 1'b1);
    u_host.read(10'h006, 1'b1, d, ak);
    check(ak, 1'b0);
    u_host.read(10'h006, 1'b0, d, ak);
    check(ak, 1'b0);
    p0 = pulses;
    u_host.write(10'h0A4, 8'h5C, 1'b1, 1'b1);
    u_host.write(10'h0A6, 8'h3C, 1'b0, 1'b1);
    check(32'(pulses - p0), 32'h1);
    rdchk(8'h3C, 32'h0);
    check({hreadyout, hresp}, 2'b10);
    $display("Test decode and attribute done");
    summarize();
  end
endmodule
`default_nettype wire
